// File: rtl/curve_interp.sv
module curve_interp
  import fan_ctrl_pkg::*;
(
  input wire logic [7:0] temp_i,
  input wire logic [fan_ctrl_pkg::NPT-1:0][7:0] pt_temp_i,
  input wire logic [fan_ctrl_pkg::NPT-1:0][7:0] pt_duty_i,
  input wire logic crit_i,
  output logic [7:0] duty_o
);

  // ==========================================================================
  // Piecewise-linear curve
  always_comb begin
    logic signed [9:0] dt;
    logic signed [9:0] span;
    logic signed [9:0] rise;
    logic signed [19:0] acc;
    logic [7:0] lo;
    logic [7:0] hi;
    dt = '0;
    span = '0;
    rise = '0;
    lo = pt_duty_i[0];
    hi = pt_duty_i[0];
    for (int k = 1; k < NPT; k++) begin
      if (pt_duty_i[k] < lo) lo = pt_duty_i[k];
      if (pt_duty_i[k] > hi) hi = pt_duty_i[k];
    end
    acc = 20'(signed'({2'b00, pt_duty_i[0]}));
    for (int k = 0; k < NPT - 1; k++) begin
      if (temp_i >= pt_temp_i[k] && temp_i < pt_temp_i[k+1]) begin
        dt = signed'({2'b00, temp_i}) - signed'({2'b00, pt_temp_i[k]});
        span = signed'({2'b00, pt_temp_i[k+1]}) - signed'({2'b00, pt_temp_i[k]});
        rise = signed'({2'b00, pt_duty_i[k+1]}) - signed'({2'b00, pt_duty_i[k]});
        acc = 20'(signed'({2'b00, pt_duty_i[k]})) + (20'(dt) * 20'(rise)) / 20'(span);
      end
    end
    if (temp_i >= pt_temp_i[NPT-1]) acc = 20'(signed'({2'b00, pt_duty_i[NPT-1]}));
    if (acc < 20'(signed'({2'b00, lo}))) acc = 20'(signed'({2'b00, lo}));
    if (acc > 20'(signed'({2'b00, hi}))) acc = 20'(signed'({2'b00, hi}));
    if (crit_i) acc = 20'(signed'({2'b00, pt_duty_i[NPT-1]}));
    duty_o = acc[7:0];
  end

endmodule // curve_interp

// File: rtl/fan_ctrl_pkg.sv
package fan_ctrl_pkg;

  // ==========================================================================
  // Sizes
  localparam int NFAN = 8;
  localparam int NSRC = 6;
  localparam int NPT = 7;
  localparam int NSENS = 8;
  localparam int ADDR_W = 10;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_MODE1 = 8'h01;
  localparam logic [7:0] IDX_MAP0 = 8'h02;
  localparam logic [7:0] IDX_MODE2 = 8'h08;
  localparam logic [7:0] IDX_PICK0 = 8'h09;
  localparam logic [7:0] IDX_DEFDUTY = 8'h0C;
  localparam logic [7:0] IDX_UPINT = 8'h0D;
  localparam logic [7:0] IDX_DNINT = 8'h0E;
  localparam logic [7:0] IDX_KIND = 8'h0F;
  localparam logic [7:0] IDX_DUTY0 = 8'h10;
  localparam logic [7:0] IDX_PRESCALE0 = 8'h18;
  localparam logic [7:0] IDX_START0 = 8'h20;
  localparam logic [7:0] IDX_NONSTOP0 = 8'h28;
  localparam logic [7:0] IDX_STOP0 = 8'h30;
  localparam logic [7:0] IDX_POL = 8'h38;
  localparam logic [7:0] IDX_GOAL0 = 8'h40;
  localparam logic [7:0] IDX_TOL = 8'h50;
  localparam logic [7:0] IDX_TARGET0 = 8'h60;
  localparam logic [7:0] IDX_CRIT0 = 8'h68;
  localparam logic [7:0] IDX_HYST0 = 8'h70;
  localparam logic [7:0] IDX_CURVE0 = 8'h80;
  localparam logic [7:0] IDX_ERRCFG0 = 8'hE0;
  localparam logic [7:0] IDX_FLOOR0 = 8'hE2;
  localparam logic [7:0] IDX_LAST = 8'hE9;
  localparam logic [7:0] CURVE_STRIDE = 8'h10;
  localparam logic [7:0] CURVE_DUTY_OFS = 8'h07;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_DEFDUTY = 8'h4D;
  localparam logic [7:0] RST_INT = 8'h80;
  localparam logic [7:0] RST_PRESCALE = 8'h84;
  localparam logic [7:0] RST_START = 8'h30;
  localparam logic [7:0] RST_NONSTOP = 8'h10;
  localparam logic [7:0] RST_STOP = 8'hFF;
  localparam logic [7:0] RST_POL = 8'hFF;
  localparam logic [7:0] RST_GOAL = 8'hA0;
  localparam logic [7:0] RST_TOL = 8'h10;
  localparam logic [7:0] RST_TARGET = 8'h28;
  localparam logic [7:0] RST_CRIT = 8'h50;
  localparam logic [7:0] RST_HYST = 8'h53;
  localparam logic [7:0] RST_FLOOR = 8'h80;

  // ==========================================================================
  // Fields, codes and timing
  localparam int HYST_HOLD_LSB = 0;
  localparam int HYST_CRIT_LSB = 4;
  localparam int ERRCFG_EN_BIT = 0;
  localparam int PICK_W = 4;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_OFF = 8'h00;
  localparam logic [7:0] TEMP_NONE = 8'h7F;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_NS = 100_000_000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_PARK = 2'b10
  } hold_state_type;

  typedef struct packed {
    logic above_hi;
    logic above_lo;
  } hold_req_type;

  function automatic logic in_block(input logic [7:0] idx, input logic [7:0] base,
                                    input int n);
    return (idx >= base) && ({1'b0, idx} < ({1'b0, base} + 9'(n)));
  endfunction

  function automatic logic [7:0] rst_val(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == IDX_DEFDUTY || in_block(idx, IDX_DUTY0, NFAN)) v = RST_DEFDUTY;
    if (idx == IDX_UPINT || idx == IDX_DNINT) v = RST_INT;
    if (in_block(idx, IDX_PRESCALE0, NFAN)) v = RST_PRESCALE;
    if (in_block(idx, IDX_START0, NFAN)) v = RST_START;
    if (in_block(idx, IDX_NONSTOP0, NFAN)) v = RST_NONSTOP;
    if (in_block(idx, IDX_STOP0, NFAN)) v = RST_STOP;
    if (idx == IDX_POL) v = RST_POL;
    if (in_block(idx, IDX_GOAL0, 2 * NFAN)) v = RST_GOAL;
    if (idx == IDX_TOL) v = RST_TOL;
    if (in_block(idx, IDX_TARGET0, NSRC)) v = RST_TARGET;
    if (in_block(idx, IDX_CRIT0, NSRC)) v = RST_CRIT;
    if (in_block(idx, IDX_HYST0, NSRC)) v = RST_HYST;
    if (in_block(idx, IDX_FLOOR0, NFAN)) v = RST_FLOOR;
    return v;
  endfunction

endpackage

// File: rtl/fan_duty_ctrl.sv
// The AXI4-Lite slave port was left to the implementer.
module fan_duty_ctrl
  import fan_ctrl_pkg::*;
#(
  parameter int TICK_LEN = fan_ctrl_pkg::TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [fan_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [fan_ctrl_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [fan_ctrl_pkg::NSENS-1:0][7:0] sensor_temp_i,
  input wire logic [fan_ctrl_pkg::NFAN-1:0][7:0] tach_period_i,
  input wire logic cpu_link_error_i,
  output logic [fan_ctrl_pkg::NFAN-1:0][7:0] fan_drive_output_o,
  output logic [fan_ctrl_pkg::NFAN-1:0] fan_warn_o,
  output logic full_speed_o
);

  // ==========================================================================
  // Register bus slave
  logic [7:0] cfg_r [0:IDX_LAST];
  logic [NFAN-1:0][7:0] duty_r;
  logic [NFAN-1:0] auto_fan;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] wr_idx_r;
  logic [7:0] wr_data_r;
  logic wr_lane_r;
  logic wr_fire;
  logic [7:0] ar_idx;

  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid_o;
  assign ar_idx = s_axi_araddr_i[ADDR_W-1:2];

  function automatic logic [7:0] fan_ofs(input logic [7:0] base, input int f);
    return base + 8'(f);
  endfunction

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      wr_idx_r <= '0;
      wr_data_r <= '0;
      wr_lane_r <= 1'b0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_r <= 1'b1;
        wr_idx_r <= s_axi_awaddr_i[ADDR_W-1:2];
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_r <= 1'b1;
        wr_data_r <= s_axi_wdata_i[7:0];
        wr_lane_r <= s_axi_wstrb_i[0];
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (wr_idx_r > IDX_LAST) ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= '0;
        s_axi_rresp_o <= RESP_OKAY;
        if (ar_idx > IDX_LAST) begin
          s_axi_rresp_o <= RESP_SLVERR;
        end else if (in_block(ar_idx, IDX_DUTY0, NFAN)) begin
          s_axi_rdata_o[7:0] <= duty_r[ar_idx - IDX_DUTY0];
        end else begin
          s_axi_rdata_o[7:0] <= cfg_r[ar_idx];
        end
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // Duty slots live in duty_r; their cfg_r copies are only loaded at reset.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i <= int'(IDX_LAST); i++) begin
        cfg_r[i] <= rst_val(8'(i));
      end
    end else if (wr_fire && wr_lane_r && wr_idx_r <= IDX_LAST &&
                 !in_block(wr_idx_r, IDX_DUTY0, NFAN)) begin
      cfg_r[wr_idx_r] <= wr_data_r;
    end
  end

  // ==========================================================================
  // Tick and temperature sources
  logic [$clog2(TICK_LEN+1)-1:0] tick_cnt_r;
  logic tick_r;
  logic [NSRC-1:0][7:0] src_temp;
  logic [NSRC-1:0] crit_r;
  hold_req_type [NSRC-1:0] src_req;
  logic [NSRC-1:0][7:0] src_curve;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (int'(tick_cnt_r) == TICK_LEN - 1);
      if (int'(tick_cnt_r) == TICK_LEN - 1) tick_cnt_r <= '0;
      else tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  always_comb begin
    logic [PICK_W-1:0] code;
    logic [8:0] t;
    logic [8:0] hy;
    code = '0;
    t = '0;
    hy = '0;
    for (int s = 0; s < NSRC; s++) begin
      code = cfg_r[IDX_PICK0 + 8'(s / 2)][(s % 2) * PICK_W +: PICK_W];
      src_temp[s] = (int'(code) < NSENS) ? sensor_temp_i[code[2:0]] : TEMP_NONE;
      t = {1'b0, cfg_r[fan_ofs(IDX_TARGET0, s)]};
      hy = {5'b0, cfg_r[fan_ofs(IDX_HYST0, s)][HYST_HOLD_LSB +: 4]};
      src_req[s].above_hi = {1'b0, src_temp[s]} > t + hy;
      src_req[s].above_lo = (t < hy) || ({1'b0, src_temp[s]} > t - hy);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      crit_r <= '0;
    end else begin
      for (int s = 0; s < NSRC; s++) begin
        if (src_temp[s] > cfg_r[fan_ofs(IDX_CRIT0, s)]) begin
          crit_r[s] <= 1'b1;
        end else if ({1'b0, src_temp[s]} + {5'b0, cfg_r[fan_ofs(IDX_HYST0, s)][HYST_CRIT_LSB +: 4]}
                     < {1'b0, cfg_r[fan_ofs(IDX_CRIT0, s)]}) begin
          crit_r[s] <= 1'b0;
        end
      end
    end
  end

  for (genvar s = 0; s < NSRC; s++) begin : g_curve
    logic [NPT-1:0][7:0] pt_t;
    logic [NPT-1:0][7:0] pt_d;
    for (genvar k = 0; k < NPT; k++) begin : g_pt
      assign pt_t[k] = cfg_r[IDX_CURVE0 + 8'(s) * CURVE_STRIDE + 8'(k)];
      assign pt_d[k] = cfg_r[IDX_CURVE0 + 8'(s) * CURVE_STRIDE + CURVE_DUTY_OFS + 8'(k)];
    end
    curve_interp u_curve (
      .temp_i(src_temp[s]),
      .pt_temp_i(pt_t),
      .pt_duty_i(pt_d),
      .crit_i(crit_r[s]),
      .duty_o(src_curve[s])
    );
  end

  // ==========================================================================
  // Per-fan control
  hold_state_type [NFAN-1:0] st_r;
  hold_state_type [NFAN-1:0] st_nxt;
  logic [NFAN-1:0][7:0] duty_nxt;
  logic [NFAN-1:0][7:0] step_cnt_r;
  logic [NFAN-1:0][7:0] step_cnt_nxt;
  logic [NFAN-1:0][7:0] park_cnt_r;
  logic [NFAN-1:0][7:0] park_cnt_nxt;
  logic [NFAN-1:0] warn_nxt;
  logic any_crit;

  assign any_crit = |crit_r;

  always_comb begin
    logic [7:0] map;
    logic has_hold;
    logic has_curve;
    logic any_hi;
    logic any_lo;
    logic up_ok;
    logic dn_ok;
    logic [7:0] cmax;
    logic [8:0] win_hi;
    logic [8:0] win_lo;
    logic [7:0] floor_v;
    map = '0;
    has_hold = 1'b0;
    has_curve = 1'b0;
    any_hi = 1'b0;
    any_lo = 1'b0;
    up_ok = 1'b0;
    dn_ok = 1'b0;
    cmax = '0;
    win_hi = '0;
    win_lo = '0;
    floor_v = '0;
    for (int f = 0; f < NFAN; f++) begin
      st_nxt[f] = st_r[f];
      duty_nxt[f] = duty_r[f];
      step_cnt_nxt[f] = step_cnt_r[f];
      park_cnt_nxt[f] = park_cnt_r[f];
      warn_nxt[f] = 1'b0;
      has_hold = 1'b0;
      has_curve = 1'b0;
      any_hi = 1'b0;
      any_lo = 1'b0;
      cmax = '0;
      for (int s = 0; s < NSRC; s++) begin
        map = cfg_r[fan_ofs(IDX_MAP0, s)];
        if (map[f] && cfg_r[IDX_MODE2][s]) begin
          has_curve = 1'b1;
          if (src_curve[s] > cmax) cmax = src_curve[s];
        end else if (map[f]) begin
          has_hold = 1'b1;
          any_hi = any_hi | src_req[s].above_hi;
          any_lo = any_lo | src_req[s].above_lo;
        end
      end
      up_ok = step_cnt_r[f] >= cfg_r[IDX_UPINT];
      dn_ok = step_cnt_r[f] >= cfg_r[IDX_DNINT];
      auto_fan[f] = cfg_r[IDX_MODE1][f] || has_hold || has_curve;
      if (!auto_fan[f] && wr_fire && wr_lane_r && wr_idx_r == fan_ofs(IDX_DUTY0, f)) begin
        duty_nxt[f] = wr_data_r;
      end
      if (tick_r && auto_fan[f]) begin
        if (step_cnt_r[f] != DUTY_FULL) step_cnt_nxt[f] = step_cnt_r[f] + 8'h01;
        if (cfg_r[IDX_MODE1][f]) begin
          win_hi = {1'b0, cfg_r[fan_ofs(IDX_GOAL0, f)]} + {1'b0, cfg_r[IDX_TOL]};
          win_lo = {1'b0, cfg_r[fan_ofs(IDX_GOAL0, f)]} - {1'b0, cfg_r[IDX_TOL]};
          if ({1'b0, tach_period_i[f]} > win_hi) begin
            if (up_ok && duty_r[f] != DUTY_FULL) begin
              duty_nxt[f] = duty_r[f] + 8'h01;
              step_cnt_nxt[f] = '0;
            end
          end else if (!win_lo[8] && {1'b0, tach_period_i[f]} < win_lo) begin
            if (dn_ok && duty_r[f] != DUTY_OFF) begin
              duty_nxt[f] = duty_r[f] - 8'h01;
              step_cnt_nxt[f] = '0;
            end
          end
        end else if (has_hold) begin
          floor_v = cfg_r[fan_ofs(IDX_NONSTOP0, f)];
          unique case (st_r[f])
            ST_OFF: begin
              if (any_lo) begin
                st_nxt[f] = ST_RUN;
                duty_nxt[f] = cfg_r[fan_ofs(IDX_START0, f)];
                step_cnt_nxt[f] = '0;
              end else begin
                duty_nxt[f] = DUTY_OFF;
              end
            end
            ST_RUN: begin
              if (any_hi) begin
                if (up_ok && duty_r[f] != DUTY_FULL) begin
                  duty_nxt[f] = duty_r[f] + 8'h01;
                  step_cnt_nxt[f] = '0;
                end
                warn_nxt[f] = (duty_r[f] == DUTY_FULL);
              end else if (!any_lo) begin
                if (duty_r[f] <= floor_v) begin
                  st_nxt[f] = (floor_v == DUTY_OFF) ? ST_OFF : ST_PARK;
                  park_cnt_nxt[f] = '0;
                end else if (dn_ok) begin
                  duty_nxt[f] = duty_r[f] - 8'h01;
                  step_cnt_nxt[f] = '0;
                end
              end
            end
            ST_PARK: begin
              if (any_lo) begin
                st_nxt[f] = ST_RUN;
              end else if (park_cnt_r[f] >= cfg_r[fan_ofs(IDX_STOP0, f)]) begin
                st_nxt[f] = ST_OFF;
                duty_nxt[f] = DUTY_OFF;
              end else begin
                park_cnt_nxt[f] = park_cnt_r[f] + 8'h01;
              end
            end
            default: st_nxt[f] = ST_OFF;
          endcase
        end
        if (!cfg_r[IDX_MODE1][f] && has_curve) begin
          if (!has_hold || cmax > duty_nxt[f]) duty_nxt[f] = cmax;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      duty_r <= {NFAN{RST_DEFDUTY}};
      st_r <= {NFAN{ST_OFF}};
      step_cnt_r <= '0;
      park_cnt_r <= '0;
    end else begin
      duty_r <= duty_nxt;
      st_r <= st_nxt;
      step_cnt_r <= step_cnt_nxt;
      park_cnt_r <= park_cnt_nxt;
    end
  end

  // ==========================================================================
  // Output stage
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fan_drive_output_o <= {NFAN{RST_DEFDUTY}};
      fan_warn_o <= '0;
      full_speed_o <= 1'b0;
    end else begin
      full_speed_o <= any_crit;
      for (int f = 0; f < NFAN; f++) begin
        if (tick_r) fan_warn_o[f] <= warn_nxt[f];
        if (any_crit) begin
          fan_drive_output_o[f] <= DUTY_FULL;
        end else if (cpu_link_error_i &&
                     cfg_r[IDX_ERRCFG0][ERRCFG_EN_BIT] &&
                     duty_r[f] < cfg_r[fan_ofs(IDX_FLOOR0, f)]) begin
          fan_drive_output_o[f] <= cfg_r[fan_ofs(IDX_FLOOR0, f)];
        end else begin
          fan_drive_output_o[f] <= duty_r[f];
        end
      end
    end
  end

endmodule // fan_duty_ctrl

// File: testbench/automatic_fan_duty_controller_bench.sv
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module automatic_fan_duty_controller_bench;
  import fan_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 0, resetn_i = 0, cpu_link_error_i = 0;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_arvalid_i = 0;
  logic s_axi_bready_i = 1, s_axi_rready_i = 1;
  logic [9:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic [NSENS-1:0][7:0] sensor_temp_i = {8{8'h20}};
  logic [NFAN-1:0][7:0] tach_period_i, fan_drive_output_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic full_speed_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
  logic [NFAN-1:0] fan_warn_o;
  logic [7:0] rd;
  int num_errors = 0, tests_run = 0, cyc = 0;
  localparam logic [15:0] ROWS [21] = '{16'h0100, 16'h0800, 16'h0200, 16'h0900, 16'h0D80,
    16'h0E80, 16'h0C4D, 16'h104D, 16'h174D, 16'h1884, 16'h2030, 16'h2810, 16'h30FF, 16'h38FF,
    16'h40A0, 16'h5010, 16'h6028, 16'h6850, 16'h7053, 16'hE000, 16'hE280};

  always #25 clk_sys_i = ~clk_sys_i;
  fan_duty_ctrl #(.TICK_LEN(20)) u_fan_duty_ctrl (.*);
  fan_plant u_fan_plant (.clk_sys_i(clk_sys_i), .duty_i(fan_drive_output_o),
    .tach_period_o(tach_period_i));

  task automatic conclude();
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= {idx, 2'b00};
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    rs = s_axi_bresp_o;
  endtask

  task automatic rdr(input logic [7:0] idx);
    @(posedge clk_sys_i);
    s_axi_araddr_i <= {idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    rd = s_axi_rdata_o[7:0];
    rs = s_axi_rresp_o;
  endtask

  task automatic tk(input int n);
    repeat (n * 20) @(posedge clk_sys_i);
  endtask

  // Cuts a hang short; the figure is several times the expected run.
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    `CHK("out", {8{8'h4D}}, fan_drive_output_o)
    foreach (ROWS[i]) begin
      rdr(ROWS[i][15:8]);
      `CHK("reg", ROWS[i][7:0], rd)
    end
    rdr(8'hF0);
    `CHK("bad_rd", {RESP_SLVERR, 8'h00}, {rs, rd})
    wr(8'hF0, 8'h11);
    `CHK("bad_wr", RESP_SLVERR, rs)
    wr(8'h10, 8'h5A);
    tk(1);
    `CHK("manual", 8'h5A, fan_drive_output_o[0])
    wr(8'hE0, 8'h01);
    cpu_link_error_i <= 1'b1;
    tk(2);
    `CHK("floor", 8'h80, fan_drive_output_o[0])
    rdr(8'h10);
    cpu_link_error_i <= 1'b0;
    `CHK("live", 8'h5A, rd)
    sensor_temp_i[0] <= 8'h60;
    tk(3);
    `CHK("crit", {8{8'hFF}}, fan_drive_output_o)
    `CHK("full", 1'b1, full_speed_o)
    sensor_temp_i[0] <= 8'h4C;
    tk(3);
    `CHK("crit_hyst", {8{8'hFF}}, fan_drive_output_o)
    sensor_temp_i[0] <= 8'h20;
    tk(3);
    `CHK("crit_off", 8'h5A, fan_drive_output_o[0])
    wr(8'h0D, 8'h01);
    wr(8'h0E, 8'h01);
    wr(8'h31, 8'h02);
    wr(8'h02, 8'h02);
    tk(4);
    `CHK("hold_off", 8'h00, fan_drive_output_o[1])
    sensor_temp_i[0] <= 8'h28;
    tk(4);
    `CHK("start", 8'h30, fan_drive_output_o[1])
    sensor_temp_i[0] <= 8'h30;
    tk(6);
    `CHK("ramp", 1'b1, fan_drive_output_o[1] inside {[8'h31:8'h36]})
    sensor_temp_i[0] <= 8'h20;
    tk(2);
    `CHK("slow", 1'b1, fan_drive_output_o[1] > 8'h10)
    tk(100);
    `CHK("stop", 8'h00, fan_drive_output_o[1])
    wr(8'h21, 8'hFF);
    sensor_temp_i[0] <= 8'h30;
    tk(4);
    `CHK("warn", 1'b1, fan_warn_o[1])
    wr(8'h08, 8'h02);
    wr(8'h09, 8'h10);
    wr(8'h96, 8'h80);
    wr(8'h9D, 8'h80);
    wr(8'h03, 8'h08);
    tk(2);
    `CHK("curve", 8'h20, fan_drive_output_o[3])
    sensor_temp_i[1] <= 8'h60;
    tk(2);
    rdr(8'h13);
    `CHK("curve_crit", 8'h80, rd)
    sensor_temp_i[1] <= 8'h20;
    tk(2);
    `CHK("curve_back", 8'h20, fan_drive_output_o[3])
    wr(8'h01, 8'h04);
    tk(10);
    `CHK("track_up", 8'h4F, fan_drive_output_o[2])
    wr(8'h42, 8'hD0);
    tk(40);
    `CHK("track_dn", 8'h3F, fan_drive_output_o[2])
    conclude();
  end
endmodule // automatic_fan_duty_controller_bench

// File: testbench/fan_duty_ctrl_asserts.sv
module fan_duty_ctrl_asserts
  import fan_ctrl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [fan_ctrl_pkg::NFAN-1:0][7:0] fan_drive_output_o,
  input wire logic full_speed_o
);
  // ==========================================================================
  // Bus and override checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o |=> ##1 s_axi_bvalid_o) else $error("write answer late");
  write_release_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o &&
    s_axi_awready_o && s_axi_wready_o) else $error("write not released");
  write_single_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("second write accepted");
  read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o &&
    !s_axi_arready_o) else $error("read answer late");
  read_release_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o &&
    s_axi_arready_o) else $error("read not released");
  rdata_upper_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("read upper bits set");
  refused_data_a: assert property (s_axi_rvalid_o && s_axi_rresp_o != RESP_OKAY |->
    s_axi_rdata_o == 32'h0) else $error("refused read carries data");
  crit_full_a: assert property (full_speed_o [*3] |->
    fan_drive_output_o == {8{8'hFF}}) else $error("critical state without full drive");
  cover property (full_speed_o);
  cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
  cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_OKAY);
endmodule // fan_duty_ctrl_asserts

bind fan_duty_ctrl fan_duty_ctrl_asserts u_fan_duty_ctrl_asserts (.*);

// File: testbench/fan_plant.sv
module fan_plant (
  input wire logic clk_sys_i,
  input wire logic [7:0][7:0] duty_i,
  output logic [7:0][7:0] tach_period_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // period count
  // A faster fan gives a shorter period, so the count falls as the duty rises.
  always_ff @(posedge clk_sys_i) begin
    tach_period_o <= ~duty_i;
  end
endmodule // fan_plant
